// file: dv/dma_priority_address_properties.sv
// Assertions on the DMA arbitration and address stream ports
`timescale 1ns/10ps
`default_nettype none
module dma_priority_address_properties (
	// Clock and reset
	input wire logic                     clk,
	input wire logic                     reset,
	// Pins and competing requests
	input wire logic [7:0]               dma_acknowledge_n,
	input wire logic                     main_memory_grant_n,
	input wire logic                     main_memory_request_n,
	input wire logic                     cpu_bus_request,
	input wire logic                     refresh_request,
	input wire logic                     nmi_pending,
	input wire logic                     guaranteed_access_mode,
	input wire dma_pkg::chan_cfg_t [7:0] channel_config,
	// Status and stream
	input wire logic [7:0]               extended_mode,
	input wire logic [7:0]               mask_status,
	input wire logic                     out_valid,
	input wire dma_pkg::xfer_t           out_xfer
);
	logic [2:0] owner;
	logic [9:0] held;
	logic       fast_busy;
	always_comb begin
		owner = 3'h0;
		for (int i = 0; i < 8; i++)
			if (!dma_acknowledge_n[i])
				owner = 3'(i);
	end
	assign fast_busy = !(&dma_acknowledge_n) && channel_config[owner].timing != dma_pkg::TIMING_COMPAT
		&& !channel_config[owner].cascade && (cpu_bus_request || refresh_request);
	// Cycles a fast owner has kept the bus against a competitor
	always_ff @(posedge clk or posedge reset) begin
		if (reset)
			held <= 10'h000;
		else
			held <= fast_busy ? held + 10'h001 : 10'h000;
	end
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	a_one_owner: assert property ($onehot0(~dma_acknowledge_n)) else $error("two acknowledges low");
	a_cascade_only: assert property (dma_acknowledge_n[4]) else $error("channel 4 acknowledged");
	a_grant_first: assert property (guaranteed_access_mode && $fell(&dma_acknowledge_n)
		|-> !$past(main_memory_grant_n, 2)) else $error("ack before memory grant");
	a_mem_request: assert property (guaranteed_access_mode && $fell(&dma_acknowledge_n)
		|-> !main_memory_request_n) else $error("ack without memory request");
	a_nmi_skip: assert property ($fell(&dma_acknowledge_n)
		|-> !($past(nmi_pending) && $past(cpu_bus_request))) else $error("dma granted during nmi");
	a_release_gap: assert property ($rose(&dma_acknowledge_n) |=> &dma_acknowledge_n)
		else $error("no release gap");
	a_compat_page: assert property (out_valid && !extended_mode[out_xfer.channel]
		|-> out_xfer.address[31:24] == 8'h00) else $error("high page not zero");
	a_shift_a0: assert property (out_valid && channel_config[out_xfer.channel].size == dma_pkg::SIZE_16_WORDS
		|-> !out_xfer.address[0]) else $error("shifted a0 set");
	a_reset_state: assert property (disable iff (1'b0) reset |-> &dma_acknowledge_n && main_memory_request_n
		&& mask_status == 8'hFF && extended_mode == 8'h00 && !out_valid) else $error("bad reset state");
	a_preempt_bound: assert property (held < 10'd400) else $error("fast owner kept bus");
endmodule
bind dma_priority_address dma_priority_address_properties i_dma_priority_address_properties (
	.clk(clk), .reset(reset), .dma_acknowledge_n(dma_acknowledge_n), .main_memory_grant_n(main_memory_grant_n),
	.main_memory_request_n(main_memory_request_n), .cpu_bus_request(cpu_bus_request),
	.refresh_request(refresh_request), .nmi_pending(nmi_pending), .guaranteed_access_mode(guaranteed_access_mode),
	.channel_config(channel_config), .extended_mode(extended_mode), .mask_status(mask_status),
	.out_valid(out_valid), .out_xfer(out_xfer)
);
`default_nettype wire

// file: dv/isa_far_side.sv
// DMA slave request lines and main memory arbiter model
`timescale 1ns/10ps
`default_nettype none
module isa_far_side (
	// Clock and reset
	input wire logic        clk,
	input wire logic        reset,
	// Bench control
	input wire logic [7:0]  want,
	input wire logic        slow,
	// Pins
	input wire logic        main_memory_request_n,
	output logic [7:0]      dma_request_line,
	output var logic        main_memory_grant_n
);
	logic [4:0] dly;
	assign dma_request_line = want;
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			dly <= 5'h00;
			main_memory_grant_n <= 1'b1;
		end else if (main_memory_request_n) begin
			dly <= 5'h00;
			main_memory_grant_n <= 1'b1;
		end else begin
			dly <= dly + 5'h01;
			if (dly >= (slow ? 5'h14 : 5'h00))
				main_memory_grant_n <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// file: dv/tb.sv
// Self-checking bench for DMA arbitration and address generation
`timescale 1ns/10ps
`default_nettype none
module tb;
	logic        clk, reset, bus_clock, cpu_bus_request, refresh_request, nmi_pending, gat, slow, tcd, rel;
	logic        reg_write_valid, cycle_done, cycle_ready, terminal_count, out_valid, out_ready;
	logic        main_memory_grant_n, main_memory_request_n;
	logic [1:0]  group_rotate, master_clear, clear_mask;
	logic [2:0]  terminal_channel, g, tcq [$], chq [$];
	logic [2:0]  ord [2][4] = '{'{3'h0, 3'h1, 3'h5, 3'h7}, '{3'h0, 3'h5, 3'h7, 3'h1}};
	logic [2:0]  ach [4] = '{3'h1, 3'h2, 3'h5, 3'h6};
	logic        ax [4] = '{1'b1, 1'b0, 1'b0, 1'b1};
	logic [31:0] aad [4] = '{32'h1234_FFFE, 32'hAB12_0001, 32'h0056_7FFF, 32'h8000_0010};
	logic [7:0]  dma_request_line, dma_acknowledge_n, extended_mode, mask_status, want, ext;
	logic [15:0] cbase [8], ccnt [8];
	logic [31:0] base [8], cur [8], exq [$];
	integer      seed, mismatches, check_count, cyc, t0;
	dma_pkg::chan_cfg_t [7:0] channel_config;
	dma_pkg::reg_write_t      reg_write;
	dma_pkg::xfer_t           out_xfer;
	dma_priority_address i_dma_priority_address (.clk(clk), .reset(reset), .bus_clock(bus_clock),
		.dma_request_line(dma_request_line), .main_memory_grant_n(main_memory_grant_n),
		.dma_acknowledge_n(dma_acknowledge_n), .main_memory_request_n(main_memory_request_n),
		.cpu_bus_request(cpu_bus_request), .refresh_request(refresh_request), .nmi_pending(nmi_pending),
		.group_rotate(group_rotate), .guaranteed_access_mode(gat), .channel_config(channel_config),
		.reg_write_valid(reg_write_valid), .reg_write(reg_write), .master_clear(master_clear),
		.clear_mask(clear_mask), .cycle_done(cycle_done), .cycle_ready(cycle_ready),
		.terminal_count(terminal_count), .terminal_channel(terminal_channel), .extended_mode(extended_mode),
		.mask_status(mask_status), .out_valid(out_valid), .out_xfer(out_xfer), .out_ready(out_ready));
	isa_far_side i_isa_far_side (.clk(clk), .reset(reset), .want(want), .slow(slow),
		.main_memory_request_n(main_memory_request_n), .dma_request_line(dma_request_line),
		.main_memory_grant_n(main_memory_grant_n));
	task automatic summarize();
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] v);
		check_count++;
		if (v !== e) begin
			mismatches++;
			$display("wrong value %s exp %h got %h", n, e, v);
		end
	endtask
	task automatic wr(input logic [2:0] ch, input logic [2:0] s, input logic [7:0] d);
		@(posedge clk);
		reg_write_valid <= 1'b1;
		reg_write <= '{ch, s, d};
		if (s < 3'h4) begin
			cur[ch][s*8+:8] = d;
			base[ch][s*8+:8] = d;
			ext[ch] = (s == dma_pkg::SEL_ADDR_HIGH);
		end else begin
			ccnt[ch][(s-4)*8+:8] = d;
			cbase[ch][(s-4)*8+:8] = d;
		end
		@(posedge clk);
		reg_write_valid <= 1'b0;
	endtask
	task automatic prog(input logic [2:0] ch, input logic [31:0] a, input logic x, input logic [15:0] n);
		logic [2:0] s;
		for (int i = 0; i < 6; i++) begin
			s = (i > 3 || x) ? 3'(i) : 3'((i + 3) % 4);
			wr(ch, s, s > 3 ? n[(s-4)*8+:8] : a[s*8+:8]);
		end
		@(posedge clk);
		clear_mask <= 2'h3;
		@(posedge clk);
		clear_mask <= 2'h0;
	endtask
	function automatic logic [31:0] oa(input logic [2:0] ch);
		logic [31:0] a;
		a = cur[ch];
		if (channel_config[ch].size == dma_pkg::SIZE_16_WORDS)
			a = {a[31:17], a[15:0], 1'b0};
		if (!ext[ch])
			a[31:24] = 8'h00;
		return a;
	endfunction
	task automatic pulse(input logic [2:0] ch);
		logic [31:0] a, st;
		do @(negedge clk); while (cycle_ready !== 1'b1);
		@(posedge clk);
		cycle_done <= 1'b1;
		exq.push_back(oa(ch));
		chq.push_back(ch);
		st = channel_config[ch].size == dma_pkg::SIZE_16_BYTES ? 32'h0000_0002 : 32'h0000_0001;
		a = channel_config[ch].decrement ? cur[ch] - st : cur[ch] + st;
		cur[ch] = ext[ch] ? a : {cur[ch][31:16], a[15:0]};
		if (ccnt[ch] == 16'h0000) begin
			tcq.push_back(ch);
			want[ch] <= 1'b0;
			tcd = 1'b1;
			cur[ch] = base[ch];
			ccnt[ch] = cbase[ch];
		end else
			ccnt[ch]--;
		@(posedge clk);
		cycle_done <= 1'b0;
		repeat (12) begin
			@(posedge clk);
			if (dma_acknowledge_n[ch] !== 1'b0)
				rel = 1'b1;
		end
	endtask
	task automatic grant(output logic [2:0] o);
		do @(negedge clk); while (dma_acknowledge_n === 8'hFF);
		for (int i = 0; i < 8; i++)
			if (dma_acknowledge_n[i] === 1'b0)
				o = 3'(i);
	endtask
	task automatic serve(input logic [2:0] ch);
		tcd = 1'b0;
		rel = 1'b0;
		while (!rel && !tcd)
			pulse(ch);
	endtask
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	initial begin
		bus_clock = 1'b0;
		#7;
		forever #160 bus_clock = ~bus_clock;
	end
	always @(posedge clk) begin
		cyc++;
		out_ready <= ($random(seed) & 3) != 0;
		if (cyc == 20000) begin
			mismatches++;
			summarize();
		end
		if (!reset && out_valid === 1'b1 && out_ready)
			chk("address", exq.pop_front(), out_xfer.address);
		if (!reset && out_valid === 1'b1 && out_ready)
			chk("xfer channel", chq.pop_front(), out_xfer.channel);
		if (!reset && terminal_count === 1'b1)
			chk("tc channel", tcq.pop_front(), terminal_channel);
	end
	initial begin
		{cpu_bus_request, refresh_request, nmi_pending, gat, slow, reg_write_valid, cycle_done, out_ready} = '0;
		{group_rotate, master_clear, clear_mask, want, ext} = '0;
		reg_write = '0;
		reset <= 1'b1;
		seed = 9623;
		mismatches = 0;
		check_count = 0;
		cyc = 0;
		for (int i = 0; i < 8; i++)
			channel_config[i] = '{2'h0, i > 4 ? dma_pkg::SIZE_16_WORDS : 2'h0, 1'b0, 1'b1, 1'b0, i == 4};
		channel_config[2].decrement = 1'b1;
		channel_config[6].size = dma_pkg::SIZE_16_BYTES;
		channel_config[3].timing = 2'h1;
		channel_config[3].block_mode = 1'b1;
		repeat (12) @(posedge clk);
		reset <= 1'b0;
		@(negedge clk);
		chk("reset ack", 8'hFF, dma_acknowledge_n);
		chk("reset mask", 8'hFF, mask_status);
		chk("reset ext", 8'h00, extended_mode);
		for (int k = 0; k < 4; k++)
			prog(ord[0][k], {29'h0, ord[0][k]}, 1'b0, 16'h0000);
		for (int m = 0; m < 2; m++) begin
			@(posedge clk);
			group_rotate <= m ? 2'h3 : 2'h0;
			want <= 8'hA3;
			for (int k = 0; k < 4; k++) begin
				grant(g);
				chk("grant order", ord[m][k], g);
				serve(g);
				chk("autoinit mask", 1'b0, mask_status[g]);
			end
		end
		@(posedge clk);
		group_rotate <= 2'h0;
		for (int k = 0; k < 4; k++) begin
			gat <= k == 3;
			slow <= k == 3;
			prog(ach[k], aad[k], ax[k], 16'h0002);
			@(negedge clk);
			chk("extended", ax[k], extended_mode[ach[k]]);
			@(posedge clk);
			want[ach[k]] <= 1'b1;
			grant(g);
			chk("grant", ach[k], g);
			serve(g);
		end
		prog(3'h0, 32'h0000_0200, 1'b0, 16'h0018);
		@(posedge clk);
		gat <= 1'b0;
		nmi_pending <= 1'b1;
		cpu_bus_request <= 1'b1;
		want[0] <= 1'b1;
		repeat (20) @(negedge clk);
		chk("nmi ack", 8'hFF, dma_acknowledge_n);
		@(posedge clk);
		nmi_pending <= 1'b0;
		grant(g);
		serve(g);
		chk("compat kept bus", 1'b1, tcd);
		prog(3'h3, 32'h0000_4000, 1'b0, 16'h001E);
		@(posedge clk);
		cpu_bus_request <= 1'b0;
		want[3] <= 1'b1;
		grant(g);
		@(posedge clk);
		refresh_request <= 1'b1;
		want[3] <= 1'b0;
		t0 = cyc;
		serve(g);
		chk("preempt window", 1'b1, cyc - t0 >= 240 && cyc - t0 <= 330 && !tcd);
		@(posedge clk);
		want[3] <= 1'b0;
		refresh_request <= 1'b0;
		grant(g);
		chk("pending regrant", 3'h3, g);
		serve(g);
		@(posedge clk);
		reset <= 1'b1;
		@(posedge clk);
		reset <= 1'b0;
		@(negedge clk);
		chk("ext after reset", 8'h00, extended_mode);
		summarize();
	end
endmodule
`default_nettype wire

// file: shared/dma_pkg.sv
// Constants and types for DMA channel arbitration and address generation
`default_nettype none
package dma_pkg;
	localparam int           NUM_CH        = 8;
	localparam logic [7:0]   CH_USABLE     = 8'hEF;
	localparam logic [7:0]   MASK_RESET    = 8'hFF;
	localparam logic [1:0]   TIMING_COMPAT = 2'h0;
	localparam logic [1:0]   SIZE_16_WORDS = 2'h1;
	localparam logic [1:0]   SIZE_16_BYTES = 2'h2;
	localparam logic [2:0]   SEL_ADDR_HIGH = 3'h3;
	localparam logic [2:0]   SEL_COUNT_LOW = 3'h4;
	localparam logic [31:0]  ADDR_RESET    = 32'h0000_0000;
	localparam logic [15:0]  COUNT_RESET   = 16'h0000;
	localparam logic [5:0]   PREEMPT_BCLK  = 6'h20;
	localparam logic [1:0]   UPPER_LOW_SLOT = 2'h3;
	localparam logic [2:0]   UPPER_BASE_CH = 3'h5;

	typedef enum logic [1:0] {
		ST_IDLE     = 2'b00,
		ST_MEM_WAIT = 2'b01,
		ST_OWN      = 2'b10,
		ST_RELEASE  = 2'b11
	} arb_state_t;

	typedef struct packed {
		logic [1:0] timing;
		logic [1:0] size;
		logic       decrement;
		logic       autoinit;
		logic       block_mode;
		logic       cascade;
	} chan_cfg_t;

	typedef struct packed {
		logic [2:0] channel;
		logic [2:0] byte_sel;
		logic [7:0] data;
	} reg_write_t;

	typedef struct packed {
		logic [2:0]  channel;
		logic [31:0] address;
	} xfer_t;
endpackage
`default_nettype wire

// file: src/base_memory.sv
// Byte-writable memory holding the base address and count of each channel
`timescale 1ns/10ps
`default_nettype none
module base_memory #(
	parameter int WIDTH = 48,
	parameter int DEPTH = 8,
	parameter int AW    = 3
) (
	// Clock
	input  wire logic                 clk,
	// Write port
	input  wire logic                 wr_en,
	input  wire logic [AW-1:0]        wr_addr,
	input  wire logic [WIDTH/8-1:0]   wr_bytes,
	input  wire logic [WIDTH-1:0]     wr_data,
	// Registered read port
	input  wire logic [AW-1:0]        rd_addr,
	output logic      [WIDTH-1:0]     rd_data
);
	logic [WIDTH-1:0] mem [DEPTH];

	always_ff @(posedge clk) begin
		for (int b = 0; b < WIDTH / 8; b++) begin
			if (wr_en && wr_bytes[b]) begin
				mem[wr_addr][b*8 +: 8] <= wr_data[b*8 +: 8];
			end
		end
		rd_data <= mem[rd_addr];
	end
endmodule
`default_nettype wire

// file: src/dma_priority_address.sv
// Channel arbitration, preemption and address generation for seven DMA channels
`timescale 1ns/10ps
`default_nettype none
module dma_priority_address (
	// Clock and reset
	input  wire logic                         clk,
	input  wire logic                         reset,
	// ISA side pins
	input  wire logic                         bus_clock,
	input  wire logic [7:0]                   dma_request_line,
	input  wire logic                         main_memory_grant_n,
	output logic      [7:0]                   dma_acknowledge_n,
	output logic                              main_memory_request_n,
	// Competing requesters and configuration
	input  wire logic                         cpu_bus_request,
	input  wire logic                         refresh_request,
	input  wire logic                         nmi_pending,
	input  wire logic [1:0]                   group_rotate,
	input  wire logic                         guaranteed_access_mode,
	input  wire dma_pkg::chan_cfg_t [7:0]     channel_config,
	// Processor writes and commands
	input  wire logic                         reg_write_valid,
	input  wire dma_pkg::reg_write_t          reg_write,
	input  wire logic [1:0]                   master_clear,
	input  wire logic [1:0]                   clear_mask,
	// Transfer engine
	input  wire logic                         cycle_done,
	output logic                              cycle_ready,
	output logic                              terminal_count,
	output logic      [2:0]                   terminal_channel,
	output logic      [7:0]                   extended_mode,
	output logic      [7:0]                   mask_status,
	// Address stream
	output logic                              out_valid,
	output dma_pkg::xfer_t                    out_xfer,
	input  wire logic                         out_ready
);
	// Pick the first requester at or after the pointer
	function automatic logic [2:0] pick4(input logic [3:0] req, input logic [1:0] ptr);
		logic [1:0] idx;
		logic [2:0] res;
		res = 3'h0;
		for (int i = 3; i >= 0; i--) begin
			idx = ptr + 2'(i);
			if (req[idx]) begin
				res = {1'b1, idx};
			end
		end
		return res;
	endfunction

	// Expand per-group command bits to channel bits
	function automatic logic [7:0] group_bits(input logic [1:0] grp);
		return {{4{grp[1]}}, {4{grp[0]}}};
	endfunction

	// Synchronisers for pins
	logic [7:0] dma_request_line_meta;
	logic [7:0] dma_request_line_sync;
	logic       grant_meta;
	logic       grant_sync_n;
	logic       bclk_meta;
	logic       bclk_sync;
	logic       bclk_prev;

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			dma_request_line_meta    <= 8'h00;
			dma_request_line_sync    <= 8'h00;
			grant_meta   <= 1'b1;
			grant_sync_n <= 1'b1;
			bclk_meta    <= 1'b0;
			bclk_sync    <= 1'b0;
			bclk_prev    <= 1'b0;
		end else begin
			dma_request_line_meta    <= dma_request_line;
			dma_request_line_sync    <= dma_request_line_meta;
			grant_meta   <= main_memory_grant_n;
			grant_sync_n <= grant_meta;
			bclk_meta    <= bus_clock;
			bclk_sync    <= bclk_meta;
			bclk_prev    <= bclk_sync;
		end
	end

	wire bclk_rise = bclk_sync & ~bclk_prev;

	// Control state
	dma_pkg::arb_state_t state;
	dma_pkg::arb_state_t next_state;
	logic [2:0]  owner;
	logic [1:0]  rot_low;
	logic [1:0]  rot_up;
	logic [7:0]  mask;
	logic [7:0]  block_pending;
	logic [7:0]  extended;
	logic [5:0]  preempt_count;
	logic        preempt_run;
	logic [31:0] cur_addr [8];
	logic [15:0] cur_count [8];
	logic [47:0] base_rd;
	logic        buf_in_ready;

	// Arbitration
	wire [7:0] live_req = (dma_request_line_sync | block_pending) & ~mask & dma_pkg::CH_USABLE;
	wire [2:0] low_pick = pick4(live_req[3:0], rot_low);
	wire [3:0] up_req   = {low_pick[2], live_req[7:5]};
	wire [2:0] up_pick  = pick4(up_req, rot_up);
	wire       win_low  = up_pick[1:0] == dma_pkg::UPPER_LOW_SLOT;
	wire [2:0] win_ch   = win_low ? {1'b0, low_pick[1:0]} : {1'b0, up_pick[1:0]} + dma_pkg::UPPER_BASE_CH;
	wire       bypass   = nmi_pending & cpu_bus_request;
	wire       can_win  = up_pick[2] & ~bypass;

	// Owner view
	dma_pkg::chan_cfg_t ocfg;
	assign ocfg = channel_config[owner];
	wire       own_cascade = ocfg.cascade | (owner == 3'h4);
	wire       own_fast    = (ocfg.timing != dma_pkg::TIMING_COMPAT) & ~own_cascade;
	wire [7:0] owner_bit   = 8'h01 << owner;
	wire       competing   = cpu_bus_request | refresh_request | (|(live_req & ~owner_bit));
	wire       expired     = preempt_count == dma_pkg::PREEMPT_BCLK;
	wire       in_own      = state == dma_pkg::ST_OWN;
	wire       xfer_accept = in_own & cycle_done & ~own_cascade & buf_in_ready;
	wire       at_tc       = cur_count[owner] == dma_pkg::COUNT_RESET;
	wire       tc_event    = xfer_accept & at_tc;
	wire       preempt_end = expired & xfer_accept & ~at_tc;
	wire       req_gone    = ~dma_request_line_sync[owner] & (own_cascade | ~ocfg.block_mode);
	wire       release_now = in_own & (tc_event | preempt_end | req_gone);

	// Address formation
	wire [31:0] own_addr = cur_addr[owner];
	wire [31:0] eff_addr = extended[owner] ? own_addr : {8'h00, own_addr[23:0]};
	wire        shifted  = ocfg.size == dma_pkg::SIZE_16_WORDS;
	wire [31:0] out_addr = shifted ? {eff_addr[31:17], eff_addr[15:0], 1'b0} : eff_addr;
	wire [31:0] step     = (ocfg.size == dma_pkg::SIZE_16_BYTES) ? 32'h0000_0002 : 32'h0000_0001;
	wire [31:0] stepped  = ocfg.decrement ? own_addr - step : own_addr + step;
	wire [31:0] next_addr = extended[owner] ? stepped : {own_addr[31:16], stepped[15:0]};

	dma_pkg::xfer_t buf_in;
	assign buf_in = '{channel: owner, address: out_addr};

	// Register write decode
	wire [5:0]  wr_bytes = 6'h01 << reg_write.byte_sel;
	wire [47:0] wr_data  = {6{reg_write.data}};
	wire        wr_high  = reg_write.byte_sel == dma_pkg::SEL_ADDR_HIGH;
	wire        wr_low   = reg_write.byte_sel < dma_pkg::SEL_ADDR_HIGH;
	wire        wr_count = reg_write.byte_sel >= dma_pkg::SEL_COUNT_LOW;
	wire [7:0]  clr_bits = group_bits(master_clear);
	wire [7:0]  unmask   = group_bits(clear_mask);

	// Next state and rotation slot
	wire [1:0] own_slot = owner[2] ? 2'(owner - dma_pkg::UPPER_BASE_CH) : dma_pkg::UPPER_LOW_SLOT;

	always_comb begin
		next_state = state;
		case (state)
			dma_pkg::ST_IDLE: begin
				if (can_win) begin
					next_state = guaranteed_access_mode ? dma_pkg::ST_MEM_WAIT : dma_pkg::ST_OWN;
				end
			end
			dma_pkg::ST_MEM_WAIT: begin
				if (!grant_sync_n) begin
					next_state = dma_pkg::ST_OWN;
				end
			end
			dma_pkg::ST_OWN: begin
				if (release_now) begin
					next_state = dma_pkg::ST_RELEASE;
				end
			end
			dma_pkg::ST_RELEASE: begin
				next_state = dma_pkg::ST_IDLE;
			end
			default: begin
				next_state = dma_pkg::ST_IDLE;
			end
		endcase
	end

	// Arbiter state, acknowledge and memory request
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			state                 <= dma_pkg::ST_IDLE;
			owner                 <= 3'h0;
			dma_acknowledge_n     <= 8'hFF;
			main_memory_request_n <= 1'b1;
		end else begin
			state <= next_state;
			if (state == dma_pkg::ST_IDLE && can_win) begin
				owner                 <= win_ch;
				main_memory_request_n <= ~guaranteed_access_mode;
			end
			if (next_state == dma_pkg::ST_OWN && state != dma_pkg::ST_OWN) begin
				dma_acknowledge_n <= ~((state == dma_pkg::ST_IDLE ? 8'h01 << win_ch : owner_bit));
			end
			if (release_now) begin
				dma_acknowledge_n     <= 8'hFF;
				main_memory_request_n <= 1'b1;
			end
		end
	end

	// Rotation pointers, updated when a service ends
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			rot_low <= 2'h0;
			rot_up  <= dma_pkg::UPPER_LOW_SLOT;
		end else begin
			if (!group_rotate[0]) begin
				rot_low <= 2'h0;
			end else if (release_now && !owner[2]) begin
				rot_low <= owner[1:0] + 2'h1;
			end
			if (!group_rotate[1]) begin
				rot_up <= dma_pkg::UPPER_LOW_SLOT;
			end else if (release_now) begin
				rot_up <= own_slot + 2'h1;
			end
		end
	end

	// Preemption timer in bus clock edges
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			preempt_run   <= 1'b0;
			preempt_count <= 6'h00;
		end else if (!in_own || release_now) begin
			preempt_run   <= 1'b0;
			preempt_count <= 6'h00;
		end else begin
			if (own_fast && competing) begin
				preempt_run <= 1'b1;
			end
			if (preempt_run && bclk_rise && !expired) begin
				preempt_count <= preempt_count + 6'h01;
			end
		end
	end

	// Mask, block pending and addressing mode per channel
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			mask          <= dma_pkg::MASK_RESET;
			block_pending <= 8'h00;
			extended      <= 8'h00;
		end else begin
			mask <= (mask | (tc_event && !ocfg.autoinit ? owner_bit : 8'h00) | clr_bits) & ~unmask;
			block_pending <= block_pending & ~clr_bits & ~(state == dma_pkg::ST_IDLE && can_win ? 8'h01 << win_ch : 8'h00)
				| (preempt_end && ocfg.block_mode ? owner_bit : 8'h00);
			extended <= extended & ~clr_bits & ~(reg_write_valid && wr_low ? 8'h01 << reg_write.channel : 8'h00)
				| (reg_write_valid && wr_high ? 8'h01 << reg_write.channel : 8'h00);
		end
	end

	// Current address and count copies
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			for (int c = 0; c < dma_pkg::NUM_CH; c++) begin
				cur_addr[c]  <= dma_pkg::ADDR_RESET;
				cur_count[c] <= dma_pkg::COUNT_RESET;
			end
		end else begin
			if (tc_event && ocfg.autoinit) begin
				cur_addr[owner]  <= base_rd[31:0];
				cur_count[owner] <= base_rd[47:32];
			end else if (xfer_accept) begin
				cur_addr[owner]  <= next_addr;
				cur_count[owner] <= cur_count[owner] - 16'h0001;
			end
			for (int b = 0; b < 4; b++) begin
				if (reg_write_valid && wr_bytes[b]) begin
					cur_addr[reg_write.channel][b*8 +: 8] <= reg_write.data;
				end
			end
			for (int b = 0; b < 2; b++) begin
				if (reg_write_valid && wr_count && wr_bytes[b+4]) begin
					cur_count[reg_write.channel][b*8 +: 8] <= reg_write.data;
				end
			end
		end
	end

	// Status outputs
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			terminal_count   <= 1'b0;
			terminal_channel <= 3'h0;
			extended_mode    <= 8'h00;
			mask_status      <= dma_pkg::MASK_RESET;
		end else begin
			terminal_count <= tc_event;
			if (tc_event) begin
				terminal_channel <= owner;
			end
			extended_mode <= extended;
			mask_status   <= mask;
		end
	end

	// Base copies, written only by the processor
	base_memory #(
		.WIDTH (48),
		.DEPTH (dma_pkg::NUM_CH),
		.AW    (3)
	) u_base (
		.clk      (clk),
		.wr_en    (reg_write_valid),
		.wr_addr  (reg_write.channel),
		.wr_bytes (wr_bytes),
		.wr_data  (wr_data),
		.rd_addr  (owner),
		.rd_data  (base_rd)
	);

	// Address buffer toward the memory side
	xfer_buffer #(
		.WIDTH ($bits(dma_pkg::xfer_t))
	) u_buf (
		.clk       (clk),
		.reset     (reset),
		.in_valid  (xfer_accept),
		.in_data   (buf_in),
		.in_ready  (buf_in_ready),
		.out_valid (out_valid),
		.out_data  (out_xfer),
		.out_ready (out_ready)
	);

	assign cycle_ready = buf_in_ready;
endmodule
`default_nettype wire

// file: src/xfer_buffer.sv
// Two-entry buffer with valid and ready on both sides
`timescale 1ns/10ps
`default_nettype none
module xfer_buffer #(
	parameter int WIDTH = 35
) (
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             reset,
	// Fill side
	input  wire logic             in_valid,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  in_ready,
	// Drain side
	output logic                  out_valid,
	output logic      [WIDTH-1:0] out_data,
	input  wire logic             out_ready
);
	logic [WIDTH-1:0] spare;
	logic             spare_valid;
	logic             next_spare_valid;
	wire              take  = in_valid & in_ready;
	wire              shift = ~out_valid | out_ready;

	assign next_spare_valid = shift ? (spare_valid & take) : (spare_valid | take);

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			out_valid   <= 1'b0;
			spare_valid <= 1'b0;
			in_ready    <= 1'b1;
		end else begin
			if (shift) begin
				out_valid <= spare_valid | take;
			end
			spare_valid <= next_spare_valid;
			in_ready    <= ~next_spare_valid;
		end
	end

	always_ff @(posedge clk) begin
		if (shift) begin
			out_data <= spare_valid ? spare : in_data;
		end
		if (take && (spare_valid || !shift)) begin
			spare <= in_data;
		end
	end
endmodule
`default_nettype wire
